// file: hdl/hrm_decode.sv
// Host register map: address decode, fixed capability words and register storage.
// Assumes processor strobes are synchronous to core_clk and held for at least one edge.
`include "hrm_regs.svh"
`default_nettype none
module hrm_decode #(
	parameter logic [31:0] PART_ID = 32'h0000_5A5A // Arbitrary value
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire hrm_pkg::hrm_bus_req_t bus_i,
	input wire hrm_pkg::hrm_done_t done_i,
	output logic [`HRM_DATA_W-1:0] data_o,
	output logic data_oe,
	output logic periph_sel,
	output logic mem_sel,
	output logic [1:0] bank_sel_ff,
	output hrm_pkg::hrm_region_t region_ff,
	output hrm_pkg::hrm_ctrl_t ctrl_o
);
	import hrm_pkg::*;

	// Byte offset of the addressed word within the register window
	function automatic logic [9:0] word_off(input logic [7:0] idx);
		word_off = {idx, 2'b00};
	endfunction

	// Word index of a byte offset; the two low bits carry no information
	function automatic logic [7:0] word_idx(input logic [9:0] off);
		word_idx = off[9:2];
	endfunction

	// Space above the 1 kB window belongs to the memory controller
	function automatic hrm_region_t region_of(input logic [`HRM_ADDR_W-1:0] a);
		logic [9:0] off;
		off = {a[`HRM_IDX_MSB:0], 1'b0};
		if (a[`HRM_WIN_MSB:`HRM_WIN_LSB] != 6'h00)
			region_of = HRM_RGN_MEMORY;
		else if (off <= `HRM_OPER_END)
			region_of = HRM_RGN_OPER;
		else if (off <= `HRM_PERI_END)
			region_of = HRM_RGN_PERIPH;
		else
			region_of = HRM_RGN_HOST;
	endfunction

	// Only operational and host words are answered and stored here
	function automatic logic is_local(input hrm_region_t r);
		is_local = (r == HRM_RGN_OPER) || (r == HRM_RGN_HOST);
	endfunction

	function automatic logic is_writable(input logic [9:0] off);
		case (off)
			`HRM_OFF_CMD,
			`HRM_OFF_USBSTAT,
			`HRM_OFF_USBINTEN,
			`HRM_OFF_FRAME,
			`HRM_OFF_CFGFLAG,
			`HRM_OFF_PORT1,

			`HRM_OFF_ISO_SKIP,
			`HRM_OFF_ISO_LAST,
			`HRM_OFF_INT_SKIP,
			`HRM_OFF_INT_LAST,
			`HRM_OFF_ASY_SKIP,
			`HRM_OFF_ASY_LAST,

			`HRM_OFF_HWMODE,
			`HRM_OFF_SCRATCH,
			`HRM_OFF_SWRST,
			`HRM_OFF_IRQSRC,
			`HRM_OFF_IRQEN,
			`HRM_OFF_ISO_OR,
			`HRM_OFF_INT_OR,
			`HRM_OFF_ASY_OR,
			`HRM_OFF_ISO_AND,
			`HRM_OFF_INT_AND,
			`HRM_OFF_ASY_AND,
			`HRM_OFF_DMACFG,
			`HRM_OFF_BUFSTAT,
			`HRM_OFF_ASY_TMO,
			`HRM_OFF_MEMSET,
			`HRM_OFF_EDGECNT,
			`HRM_OFF_DMAADDR,
			`HRM_OFF_PWRDN:
				is_writable = 1'b1;
			default:
				is_writable = 1'b0;
		endcase
	endfunction

	// Full table of stored words, so a changed value is visible in one place
	function automatic logic [31:0] reset_val(input logic [9:0] off);
		case (off)
			`HRM_OFF_CMD:
				reset_val = `HRM_RST_CMD;
			`HRM_OFF_USBSTAT:
				reset_val = `HRM_RST_ZERO;
			`HRM_OFF_USBINTEN:
				reset_val = `HRM_RST_ZERO;
			`HRM_OFF_FRAME:
				reset_val = `HRM_RST_ZERO;
			`HRM_OFF_CFGFLAG:
				reset_val = `HRM_RST_ZERO;
			`HRM_OFF_PORT1:
				reset_val = `HRM_RST_PORT1;

			`HRM_OFF_ISO_SKIP:
				reset_val = `HRM_RST_SKIP;
			`HRM_OFF_ISO_LAST:
				reset_val = `HRM_RST_ZERO;
			`HRM_OFF_INT_SKIP:
				reset_val = `HRM_RST_SKIP;
			`HRM_OFF_INT_LAST:
				reset_val = `HRM_RST_ZERO;
			`HRM_OFF_ASY_SKIP:
				reset_val = `HRM_RST_SKIP;
			`HRM_OFF_ASY_LAST:
				reset_val = `HRM_RST_ZERO;

			`HRM_OFF_HWMODE:
				reset_val = `HRM_RST_HWMODE;
			`HRM_OFF_SCRATCH:
				reset_val = `HRM_RST_ZERO;
			`HRM_OFF_SWRST:
				reset_val = `HRM_RST_ZERO;
			`HRM_OFF_IRQSRC:
				reset_val = `HRM_RST_ZERO;
			`HRM_OFF_IRQEN:
				reset_val = `HRM_RST_ZERO;
			`HRM_OFF_ISO_OR:
				reset_val = `HRM_RST_ZERO;
			`HRM_OFF_INT_OR:
				reset_val = `HRM_RST_ZERO;
			`HRM_OFF_ASY_OR:
				reset_val = `HRM_RST_ZERO;
			`HRM_OFF_ISO_AND:
				reset_val = `HRM_RST_ZERO;
			`HRM_OFF_INT_AND:
				reset_val = `HRM_RST_ZERO;
			`HRM_OFF_ASY_AND:
				reset_val = `HRM_RST_ZERO;
			`HRM_OFF_DMACFG:
				reset_val = `HRM_RST_ZERO;
			`HRM_OFF_BUFSTAT:
				reset_val = `HRM_RST_ZERO;
			`HRM_OFF_ASY_TMO:
				reset_val = `HRM_RST_ZERO;
			`HRM_OFF_MEMSET:
				reset_val = `HRM_RST_ZERO;
			`HRM_OFF_EDGECNT:
				reset_val = `HRM_RST_EDGECNT;
			`HRM_OFF_DMAADDR:
				reset_val = `HRM_RST_ZERO;
			`HRM_OFF_PWRDN:
				reset_val = `HRM_RST_PWRDN;
			default:
				reset_val = `HRM_RST_ZERO;
		endcase
	endfunction

	logic [`HRM_DATA_W-1:0] regs_ff [0:`HRM_WORDS-1];
	hrm_access_t state_ff;
	logic [`HRM_DATA_W-1:0] rdata_ff;
	hrm_region_t req_region;
	logic [7:0] req_idx;
	logic [9:0] req_off;
	logic rd_req;
	logic wr_req;
	logic rd_start;
	logic wr_start;

	// Byte offset is {A[9:2],2'b00}; A1 is ignored since every access is a word
	assign req_idx = bus_i.addr[`HRM_IDX_MSB:`HRM_IDX_LSB];
	assign req_off = word_off(req_idx);
	assign req_region = region_of(bus_i.addr);
	assign rd_req = !bus_i.cs_n && !bus_i.rd_n;
	assign wr_req = !bus_i.cs_n && !bus_i.wr_n;
	// Read wins when both strobes are low together, so no write lands then
	assign rd_start = (state_ff == HRM_ST_IDLE) && rd_req;
	assign wr_start = (state_ff == HRM_ST_IDLE) && wr_req && !rd_req;

	function automatic logic [31:0] read_word(input logic [9:0] off, input logic [31:0] stored);
		case (off)
			`HRM_OFF_CAPLEN:
				read_word = {`HRM_VAL_VERSION, 8'h00, `HRM_VAL_CAPLEN};
			`HRM_OFF_STRUCT:
				read_word = `HRM_VAL_STRUCT;
			`HRM_OFF_CAPPAR:
				read_word = `HRM_VAL_CAPPAR;
			`HRM_OFF_ISO_DONE:
				read_word = done_i.iso_done;
			`HRM_OFF_INT_DONE:
				read_word = done_i.int_done;
			`HRM_OFF_ASY_DONE:
				read_word = done_i.asy_done;
			`HRM_OFF_PARTID:
				read_word = PART_ID;
			default:
				read_word = is_writable(off) ? stored : `HRM_RST_ZERO;
		endcase
	endfunction

	// One action per strobe: the state holds until the strobe is released
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			state_ff <= HRM_ST_IDLE;
		else
			case (state_ff)
				HRM_ST_IDLE:
					if (rd_req)
						state_ff <= HRM_ST_READ;
					else if (wr_req)
						state_ff <= HRM_ST_WRITE;
				HRM_ST_READ:
					if (!rd_req)
						state_ff <= HRM_ST_IDLE;
				HRM_ST_WRITE:
					if (!wr_req)
						state_ff <= HRM_ST_IDLE;
				default:
					state_ff <= HRM_ST_IDLE;
			endcase
	end

	// Region and bank are captured at the start of each access
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			region_ff <= HRM_RGN_OPER;
			bank_sel_ff <= 2'b00;
		end
		else if (rd_start || wr_start)
		begin
			region_ff <= req_region;
			bank_sel_ff <= bus_i.addr[`HRM_BANK_MSB:`HRM_BANK_LSB];
		end
	end

	// Peripheral words are answered elsewhere, so this block returns zero for them
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			rdata_ff <= `HRM_RST_ZERO;
		else if (rd_start)
			rdata_ff <= is_local(req_region) ? read_word(req_off, regs_ff[req_idx]) :
				`HRM_RST_ZERO;
	end

	// Unlisted words keep their zero reset and are pruned in synthesis
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < `HRM_WORDS; i++)
				regs_ff[i] <= reset_val(word_off(8'(i)));
		end
		else if (wr_start && is_writable(req_off) && is_local(req_region))
			regs_ff[req_idx] <= bus_i.wdata;
	end

	assign data_o = rdata_ff;
	assign data_oe = (state_ff == HRM_ST_READ) && is_local(region_ff);
	assign periph_sel = (state_ff != HRM_ST_IDLE) && (region_ff == HRM_RGN_PERIPH);
	assign mem_sel = (state_ff != HRM_ST_IDLE) && (region_ff == HRM_RGN_MEMORY);

	assign ctrl_o.iso_skip = regs_ff[word_idx(`HRM_OFF_ISO_SKIP)];
	assign ctrl_o.int_skip = regs_ff[word_idx(`HRM_OFF_INT_SKIP)];
	assign ctrl_o.asy_skip = regs_ff[word_idx(`HRM_OFF_ASY_SKIP)];
	assign ctrl_o.hw_mode = regs_ff[word_idx(`HRM_OFF_HWMODE)];
	assign ctrl_o.edge_count = regs_ff[word_idx(`HRM_OFF_EDGECNT)];
	assign ctrl_o.power_down = regs_ff[word_idx(`HRM_OFF_PWRDN)];
endmodule // hrm_decode
`default_nettype wire

// file: hdl/hrm_regs.svh
// Offsets, reset values and fixed capability values of the host register map.
// Assumes byte offsets within the 1 kB register window; 32-bit words only.
`ifndef HRM_REGS_SVH
`define HRM_REGS_SVH

`define HRM_ADDR_W 17
`define HRM_DATA_W 32
`define HRM_BANK_MSB 16
`define HRM_BANK_LSB 15
`define HRM_WIN_MSB 14
`define HRM_WIN_LSB 9
`define HRM_IDX_MSB 8
`define HRM_IDX_LSB 1
`define HRM_WORDS 256

`define HRM_OPER_END 10'h1FF
`define HRM_PERI_END 10'h2FF

`define HRM_OFF_CAPLEN 10'h000
`define HRM_OFF_VERSION 10'h002
`define HRM_OFF_STRUCT 10'h004
`define HRM_OFF_CAPPAR 10'h008
`define HRM_OFF_CMD 10'h020
`define HRM_OFF_USBSTAT 10'h024
`define HRM_OFF_USBINTEN 10'h028
`define HRM_OFF_FRAME 10'h02C
`define HRM_OFF_CFGFLAG 10'h060
`define HRM_OFF_PORT1 10'h064
`define HRM_OFF_ISO_DONE 10'h130
`define HRM_OFF_ISO_SKIP 10'h134
`define HRM_OFF_ISO_LAST 10'h138
`define HRM_OFF_INT_DONE 10'h140
`define HRM_OFF_INT_SKIP 10'h144
`define HRM_OFF_INT_LAST 10'h148
`define HRM_OFF_ASY_DONE 10'h150
`define HRM_OFF_ASY_SKIP 10'h154
`define HRM_OFF_ASY_LAST 10'h158
`define HRM_OFF_HWMODE 10'h300
`define HRM_OFF_PARTID 10'h304
`define HRM_OFF_SCRATCH 10'h308
`define HRM_OFF_SWRST 10'h30C
`define HRM_OFF_IRQSRC 10'h310
`define HRM_OFF_IRQEN 10'h314
`define HRM_OFF_ISO_OR 10'h318
`define HRM_OFF_INT_OR 10'h31C
`define HRM_OFF_ASY_OR 10'h320
`define HRM_OFF_ISO_AND 10'h324
`define HRM_OFF_INT_AND 10'h328
`define HRM_OFF_ASY_AND 10'h32C
`define HRM_OFF_DMACFG 10'h330
`define HRM_OFF_BUFSTAT 10'h334
`define HRM_OFF_ASY_TMO 10'h338
`define HRM_OFF_MEMSET 10'h33C
`define HRM_OFF_EDGECNT 10'h340
`define HRM_OFF_DMAADDR 10'h344
`define HRM_OFF_PWRDN 10'h354

`define HRM_VAL_CAPLEN 8'h20
`define HRM_VAL_VERSION 16'h0100
`define HRM_VAL_STRUCT 32'h0000_0011
`define HRM_VAL_CAPPAR 32'h0000_0086
`define HRM_RST_CMD 32'h0008_0B00
`define HRM_RST_PORT1 32'h0000_2000
`define HRM_RST_SKIP 32'hFFFF_FFFF
`define HRM_RST_HWMODE 32'h0000_0100
`define HRM_RST_EDGECNT 32'h0000_000F
`define HRM_RST_PWRDN 32'h03E8_1BA0
`define HRM_RST_ZERO 32'h0000_0000

`endif

// file: hdl/hrm_pkg.sv
// Types for the host register map decoder.
// Assumes hrm_regs.svh supplies the widths.
`include "hrm_regs.svh"
`default_nettype none
package hrm_pkg;
	typedef enum logic [1:0] {HRM_RGN_OPER, HRM_RGN_PERIPH, HRM_RGN_HOST, HRM_RGN_MEMORY}
		hrm_region_t;

	typedef enum logic [1:0] {HRM_ST_IDLE, HRM_ST_READ, HRM_ST_WRITE} hrm_access_t;

	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic [`HRM_ADDR_W-1:0] addr;
		logic [`HRM_DATA_W-1:0] wdata;
	} hrm_bus_req_t;

	typedef struct packed {
		logic [`HRM_DATA_W-1:0] iso_done;
		logic [`HRM_DATA_W-1:0] int_done;
		logic [`HRM_DATA_W-1:0] asy_done;
	} hrm_done_t;

	typedef struct packed {
		logic [`HRM_DATA_W-1:0] iso_skip;
		logic [`HRM_DATA_W-1:0] int_skip;
		logic [`HRM_DATA_W-1:0] asy_skip;
		logic [`HRM_DATA_W-1:0] hw_mode;
		logic [`HRM_DATA_W-1:0] edge_count;
		logic [`HRM_DATA_W-1:0] power_down;
	} hrm_ctrl_t;
endpackage
`default_nettype wire

// file: bench/hrm_props.sv
// Checker for the register map decoder, bound to its top ports.
// Assumes one clock domain and the asynchronous active-low reset.
`default_nettype none
module hrm_props import hrm_pkg::*; (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire hrm_pkg::hrm_bus_req_t bus_i,
	input wire hrm_pkg::hrm_done_t done_i,
	input wire logic [31:0] data_o,
	input wire logic data_oe,
	input wire logic periph_sel,
	input wire logic mem_sel,
	input wire logic [1:0] bank_sel_ff,
	input wire hrm_pkg::hrm_region_t region_ff,
	input wire hrm_pkg::hrm_ctrl_t ctrl_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic rq;
	logic wq;
	logic [14:0] a;
	assign rq = !bus_i.cs_n && !bus_i.rd_n;
	assign wq = !bus_i.cs_n && !bus_i.wr_n;
	assign a = bus_i.addr[14:0];
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	sequence s_rd;
		rq && !$past(rq);
	endsequence
	sequence s_go;
		(rq || wq) && !$past(rq || wq);
	endsequence
	a_caplen_word: assert property (s_rd ##0 a[14:1] == 14'h0000 |=> data_o == 32'h0100_0020)
		else $error("first word wrong");
	a_host_oe: assert property (s_rd ##0 (a[14:9] == 6'h00 && a[8:7] != 2'h2) |=> data_oe && !periph_sel)
		else $error("no drive for read");
	a_periph_sel: assert property (s_rd ##0 (a[14:9] == 6'h00 && a[8:7] == 2'h2) |=> periph_sel && !data_oe)
		else $error("peripheral decode wrong");
	a_mem_sel: assert property (s_go ##0 a[14:9] != 6'h00 |=> mem_sel && !data_oe)
		else $error("memory decode wrong");
	a_bank_latch: assert property (s_go |=> bank_sel_ff == $past(bus_i.addr[16:15]))
		else $error("bank not latched");
	a_oe_drop: assert property (data_oe && bus_i.rd_n |=> !data_oe)
		else $error("drive held too long");
	a_done_read: assert property (s_rd ##0 a == 15'h0098 |=> data_o == $past(done_i.iso_done))
		else $error("done map wrong");
	a_unmapped_zero: assert property (s_rd ##0 a == 15'h01F8 |=> data_o == 32'h0000_0000)
		else $error("unassigned word not zero");
	a_skip_write: assert property (wq && !$past(wq) && a == 15'h00A2 |=> ctrl_o.int_skip == $past(bus_i.wdata))
		else $error("skip map write lost");
	a_region_host: assert property (s_go ##0 a[14:7] == 8'h03 |=> region_ff == HRM_RGN_HOST)
		else $error("host region not latched");
endmodule // hrm_props
`default_nettype wire

// file: bench/hrm_cpu.sv
// Processor model: one full-word read or write per call on the strobe bus.
// Assumes callers run one access at a time; lines change at falling edges.
`default_nettype none
module hrm_cpu import hrm_pkg::*; (
	input wire logic core_clk,
	output var hrm_pkg::hrm_bus_req_t bus_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial bus_o = '{1'b1, 1'b1, 1'b1, 17'h00000, 32'h0000_0000};
	// Whole words only; bank on the top two lines
	task automatic acc(input logic wr, input logic [1:0] bank, input logic [15:0] off,
		input logic [31:0] d);
		@(negedge core_clk);
		bus_o = '{1'b0, wr, !wr, {bank, off[15:1]}, d};
		@(negedge core_clk);
		// Released lines flip so stale values never look valid
		bus_o = '{1'b1, 1'b1, 1'b1, ~bus_o.addr, ~bus_o.wdata};
		@(negedge core_clk);
	endtask
endmodule // hrm_cpu
`default_nettype wire

// file: bench/tb_top.sv
// Bench top: reset, register reads and writes, queued checks and verdict.
// Assumes header, package, design, checker and processor model compiled first.
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
	$display("Error %0t: got %h expected %h", $time, g, e); end end
bind hrm_decode hrm_props u_props (.core_clk(core_clk), .arst_n(arst_n), .bus_i(bus_i),
	.done_i(done_i), .data_o(data_o), .data_oe(data_oe), .periph_sel(periph_sel),
	.mem_sel(mem_sel), .bank_sel_ff(bank_sel_ff), .region_ff(region_ff), .ctrl_o(ctrl_o));
module tb_top import hrm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] PID = 32'h0000_3C3C; // Arbitrary value
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	hrm_bus_req_t bus;
	hrm_done_t done = '0;
	logic [31:0] data_o;
	logic data_oe;
	logic oe_d = 1'b0;
	hrm_ctrl_t ctrl;
	logic [31:0] q[$];
	logic [31:0] w;
	logic [31:0] exp_v;
	int n_fail = 0;
	int check_count = 0;
	logic [15:0] offs [13] = '{16'h0000, 16'h0002, 16'h0004, 16'h0008, 16'h0020, 16'h0064,
		16'h0134, 16'h0154, 16'h0300, 16'h0304, 16'h0340, 16'h0354, 16'h035C};
	logic [31:0] vals [13] = '{32'h0100_0020, 32'h0100_0020, 32'h0000_0011, 32'h0000_0086,
		32'h0008_0B00, 32'h0000_2000, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_0100, PID,
		32'h0000_000F, 32'h03E8_1BA0, 32'h0000_0000};
	always #2 core_clk = ~core_clk;
	hrm_decode #(.PART_ID(PID)) DUT (.core_clk(core_clk), .arst_n(arst_n), .bus_i(bus),
		.done_i(done), .data_o(data_o), .data_oe(data_oe), .periph_sel(), .mem_sel(),
		.bank_sel_ff(), .region_ff(), .ctrl_o(ctrl));
	hrm_cpu cpu (.core_clk(core_clk), .bus_o(bus));
	task automatic complete_run;
		if (n_fail == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic rd(input logic [15:0] off, input logic [31:0] e);
		q.push_back(e);
		cpu.acc(1'b0, 2'($urandom), off, 32'($urandom));
	endtask
	task automatic wr(input logic [15:0] off, input logic [31:0] d);
		cpu.acc(1'b1, 2'($urandom), off, d);
	endtask
	// Oldest note is matched against each new read answer
	always @(negedge core_clk)
	begin
		if (data_oe === 1'b1 && !oe_d)
		begin
			// Popped once, as the macro names its arguments twice
			exp_v = (q.size() > 0) ? q.pop_front() : 32'hXXXX_XXXX;
			`CHK(data_o, exp_v)
		end
		oe_d = data_oe === 1'b1;
	end
	initial
	begin
		repeat (5000) @(posedge core_clk);
		n_fail++;
		complete_run();
	end
	initial
	begin
		void'($urandom(32'hC2F5));
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		arst_n = 1'b1;
		`CHK(ctrl, {{3{32'hFFFF_FFFF}}, 32'h0000_0100, 32'h0000_000F, 32'h03E8_1BA0})
		`CHK({data_oe, data_o}, 33'h0_0000_0000)
		done = {32'($urandom), 32'($urandom), 32'($urandom)};
		foreach (offs[i])
			rd(offs[i], vals[i]);
		rd(16'h0130, done.iso_done);
		rd(16'h0140, done.int_done);
		rd(16'h0150, done.asy_done);
		w = $urandom;
		wr(16'h0000, w);
		wr(16'h03F0, w);
		wr(16'h0308, w);
		wr(16'h0144, w);
		rd(16'h0000, 32'h0100_0020);
		rd(16'h03F0, 32'h0000_0000);
		rd(16'h0308, w);
		`CHK(ctrl.int_skip, w)
		cpu.acc(1'b0, 2'h3, 16'h0200, w);
		cpu.acc(1'b0, 2'h1, 16'h0800, w);
		arst_n = 1'b0;
		@(negedge core_clk);
		arst_n = 1'b1;
		`CHK(ctrl.int_skip, 32'hFFFF_FFFF)
		rd(16'h0308, 32'h0000_0000);
		repeat (4) @(negedge core_clk);
		`CHK(q.size(), 0)
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
